// ==== include/tcpc_pkg.sv ====
/*
  Package for the timer / capture / PWM block: register map, field
  positions, reset values, edge-mode codes and shared carrier types.
  Assumes an APB slave with 32-bit data; each register is one word.
*/
package tcpc_pkg;

  // ==========================================================
  // Register indices as printed, and choices of our own
  // ==========================================================
  localparam logic [7:0] IDX_CONFIG = 8'h16;
  localparam logic [7:0] IDX_RUN = 8'h17;
  localparam logic [7:0] IDX_TA = 8'h20;
  localparam logic [7:0] IDX_TB = 8'h21;
  localparam logic [7:0] IDX_PA = 8'h22;
  localparam logic [7:0] IDX_PB = 8'h23;
  localparam logic [7:0] IDX_TC_LO = 8'h24;
  localparam logic [7:0] IDX_TC_HI = 8'h25;
  localparam logic [7:0] IDX_SH_LO = 8'h26;
  localparam logic [7:0] IDX_SH_HI = 8'h27;
  localparam logic [7:0] IDX_CB_LO = 8'h28;
  localparam logic [7:0] IDX_CB_HI = 8'h29;
  localparam logic [7:0] IDX_FLAGS = 8'h2a;
  localparam logic [7:0] IDX_DIR = 8'h2b;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int CFG_T1_CS = 0;
  localparam int CFG_T2_CS = 1;
  localparam int CFG_T3_CS = 2;
  localparam int CFG_PAIR = 3;
  localparam int CFG_CAP1_LO = 4;
  localparam int CFG_CAP2_LO = 6;
  localparam int RUN_T1 = 0;
  localparam int RUN_T2 = 1;
  localparam int RUN_T3 = 2;
  localparam int RUN_CAPSEL = 3;
  localparam int RUN_PWMA = 4;
  localparam int RUN_PWMB = 5;
  localparam int RUN_OVR1 = 6;
  localparam int RUN_OVR2 = 7;
  localparam int PWMA_PIN = 2;
  localparam int PWMB_PIN = 3;
  // Flags word: timer_a, timer_b, timer_c, capture_a, capture_b
  localparam int FLG_TA = 0;
  localparam int FLG_TB = 1;
  localparam int FLG_TC = 2;
  localparam int FLG_CA = 3;
  localparam int FLG_CB = 4;
  localparam int FLG_W = 5;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'hff;
  localparam logic [1:0] RUN_WMASK_HI = 2'h0;

  // Internal clock is pclk / 4, as an instruction clock
  localparam logic [1:0] PRESCALE_LAST = 2'h3;

  typedef enum logic [1:0] {
    TCPC_EDGE_FALL = 2'h0,
    TCPC_EDGE_RISE = 2'h1,
    TCPC_EDGE_RISE4 = 2'h2,
    TCPC_EDGE_RISE16 = 2'h3
  } tcpc_edge_t;

  localparam logic [3:0] DIV4_LAST = 4'h3;
  localparam logic [3:0] DIV16_LAST = 4'hf;

  // Capture channel state, carried together
  typedef struct packed {
    logic [15:0] value;
    logic lo_read;
    logic hi_read;
    logic overrun;
  } tcpc_cap_t;

endpackage : tcpc_pkg

// ==== hdl/tcpc_top.sv ====
/*
  Timer / capture / PWM block: timers A and B (8-bit, chainable),
  timer C (16-bit) with two capture channels, PWM pin direction.
  Assumes an APB master on pclk and asynchronous pins on the inputs.
*/
module tcpc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_clk_ab,
  input wire logic ext_clk_c,
  input wire logic cap_a_pin,
  input wire logic cap_b_pin,
  output logic [5:0] irq_flags,
  output logic pwm_a_oe,
  output logic pwm_b_oe,
  output logic pwm_period_a,
  output logic pwm_period_b
);

  // ==========================================================
  // Registers
  // ==========================================================
  logic [7:0] timer_config_reg;
  logic [7:0] timer_run_control_reg;
  logic [7:0] portb_direction_reg;
  logic [7:0] timer_a_reg, timer_b_reg, period_a_reg, period_b_reg;
  logic [15:0] timer_c_reg, period_c_reg;
  logic [4:0] flags_reg;
  tcpc_pkg::tcpc_cap_t cap_reg [2];
  logic [1:0] prescale_reg;
  logic [2:0] sync_reg [4];
  logic [3:0] div_reg [2];

  // Decode helper used for every access
  function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
    hit = (a[11:2] == {2'h0, idx});
  endfunction : hit

  logic wr, rd, mapped;
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign mapped = hit(paddr, tcpc_pkg::IDX_CONFIG) |
    hit(paddr, tcpc_pkg::IDX_RUN) | hit(paddr, tcpc_pkg::IDX_DIR) |
    (paddr[11:2] >= {2'h0, tcpc_pkg::IDX_TA} &&
     paddr[11:2] <= {2'h0, tcpc_pkg::IDX_FLAGS});
  assign pslverr = psel & penable & ~mapped;

  // ==========================================================
  // Pin synchronisers: three flops, change when 2nd and 3rd agree
  // ==========================================================
  logic [3:0] pins;
  logic [3:0] fall, rise;
  assign pins = {cap_b_pin, cap_a_pin, ext_clk_c, ext_clk_ab};
  logic [3:0] lvl_reg;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync_reg[g] <= 3'h0;
          lvl_reg[g] <= 1'b0;
        end else begin
          sync_reg[g] <= {sync_reg[g][1:0], pins[g]};
          if (sync_reg[g][1] == sync_reg[g][2]) begin
            lvl_reg[g] <= sync_reg[g][2];
          end
        end
      end
      assign fall[g] = lvl_reg[g] & ~sync_reg[g][2] &
        (sync_reg[g][1] == sync_reg[g][2]);
      assign rise[g] = ~lvl_reg[g] & sync_reg[g][2] &
        (sync_reg[g][1] == sync_reg[g][2]);
    end
  endgenerate

  // Internal instruction clock tick: one pclk in four
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prescale_reg <= 2'h0;
    else prescale_reg <= prescale_reg + 2'h1;
  end
  logic int_tick;
  assign int_tick = (prescale_reg == tcpc_pkg::PRESCALE_LAST);

  // ==========================================================
  // Timers A and B
  // ==========================================================
  logic pair, tick_a, tick_b, tick_c;
  logic match_a, match_b, match_ab;
  assign pair = timer_config_reg[tcpc_pkg::CFG_PAIR];
  // Clock select per timer
  assign tick_a = timer_config_reg[tcpc_pkg::CFG_T1_CS] ? fall[0] : int_tick;
  assign tick_b = timer_config_reg[tcpc_pkg::CFG_T2_CS] ? fall[0] : int_tick;
  assign tick_c = timer_config_reg[tcpc_pkg::CFG_T3_CS] ? fall[1] : int_tick;
  assign match_a = timer_a_reg == period_a_reg;
  assign match_b = timer_b_reg == period_b_reg;
  // Pair mode compares the full 16-bit count, A low and B high
  assign match_ab = {timer_b_reg, timer_a_reg} ==
    {period_b_reg, period_a_reg};

  logic run_a, run_b, run_c, step_a, step_b, roll_a, roll_b;
  assign run_a = timer_run_control_reg[tcpc_pkg::RUN_T1];
  assign run_b = timer_run_control_reg[tcpc_pkg::RUN_T2];
  assign run_c = timer_run_control_reg[tcpc_pkg::RUN_T3];
  // Pair mode: A's run and clock drive both; B still needs its run bit
  logic carry_a;
  assign carry_a = (timer_a_reg == 8'hff); // Low byte wraps into B
  assign step_a = run_a & tick_a;
  assign step_b = pair ? (step_a & run_b & carry_a)
                       : (run_b & tick_b);
  assign roll_a = pair ? (step_a & match_ab) : (step_a & match_a);
  assign roll_b = pair ? roll_a : (run_b & tick_b & match_b);

  // Timer A: low byte in pair mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) timer_a_reg <= 8'h00;
    else if (wr && hit(paddr, tcpc_pkg::IDX_TA)) timer_a_reg <= pwdata[7:0];
    else if (roll_a) timer_a_reg <= 8'h00;
    else if (step_a) timer_a_reg <= timer_a_reg + 8'h01;
  end

  // Timer B: high byte in pair mode, carried from A wrapping past 8'hff
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) timer_b_reg <= 8'h00;
    else if (wr && hit(paddr, tcpc_pkg::IDX_TB)) timer_b_reg <= pwdata[7:0];
    else if (roll_b) timer_b_reg <= 8'h00;
    else if (step_b)
      timer_b_reg <= timer_b_reg + 8'h01;
  end

  // PWM period strobes from the A/B time base
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_period_a <= 1'b0;
      pwm_period_b <= 1'b0;
    end else begin
      pwm_period_a <= roll_a;
      pwm_period_b <= pair ? roll_a : roll_b;
    end
  end

  // PWM pins: enable overrides port direction (1 = input)
  assign pwm_a_oe = timer_run_control_reg[tcpc_pkg::RUN_PWMA] |
    ~portb_direction_reg[tcpc_pkg::PWMA_PIN];
  assign pwm_b_oe = timer_run_control_reg[tcpc_pkg::RUN_PWMB] |
    ~portb_direction_reg[tcpc_pkg::PWMB_PIN];

  // ==========================================================
  // Timer C and its period / capture pair
  // ==========================================================
  logic capsel, roll_c;
  assign capsel = timer_run_control_reg[tcpc_pkg::RUN_CAPSEL];
  assign roll_c = run_c & tick_c & ~capsel &
    (timer_c_reg == period_c_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) timer_c_reg <= 16'h0000;
    else if (wr && hit(paddr, tcpc_pkg::IDX_TC_LO))
      timer_c_reg[7:0] <= pwdata[7:0];
    else if (wr && hit(paddr, tcpc_pkg::IDX_TC_HI))
      timer_c_reg[15:8] <= pwdata[7:0];
    else if (roll_c) timer_c_reg <= 16'h0000;
    else if (run_c && tick_c) timer_c_reg <= timer_c_reg + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) period_c_reg <= 16'h0000;
    else if (wr && !capsel && hit(paddr, tcpc_pkg::IDX_SH_LO))
      period_c_reg[7:0] <= pwdata[7:0];
    else if (wr && !capsel && hit(paddr, tcpc_pkg::IDX_SH_HI))
      period_c_reg[15:8] <= pwdata[7:0];
  end

  // ==========================================================
  // Capture channels (0 = shared pair, 1 = dedicated pair)
  // ==========================================================
  logic [1:0] cap_evt;
  logic [1:0] cap_ok;
  logic [7:0] lo_idx [2];
  logic [7:0] hi_idx [2];
  assign lo_idx[0] = tcpc_pkg::IDX_SH_LO;
  assign hi_idx[0] = tcpc_pkg::IDX_SH_HI;
  assign lo_idx[1] = tcpc_pkg::IDX_CB_LO;
  assign hi_idx[1] = tcpc_pkg::IDX_CB_HI;
  assign cap_ok[0] = capsel;
  assign cap_ok[1] = 1'b1;

  generate
    for (g = 0; g < 2; g++) begin : g_cap
      tcpc_pkg::tcpc_edge_t mode;
      logic rd_lo, rd_hi, both_read;
      assign mode = tcpc_pkg::tcpc_edge_t'(timer_config_reg[
        (g ? tcpc_pkg::CFG_CAP2_LO : tcpc_pkg::CFG_CAP1_LO) +: 2]);
      // Edge selection, with prescale count of rising edges
      always_comb begin
        case (mode)
          tcpc_pkg::TCPC_EDGE_FALL: cap_evt[g] = fall[g + 2];
          tcpc_pkg::TCPC_EDGE_RISE: cap_evt[g] = rise[g + 2];
          tcpc_pkg::TCPC_EDGE_RISE4:
            cap_evt[g] = rise[g + 2] & (div_reg[g] == tcpc_pkg::DIV4_LAST);
          tcpc_pkg::TCPC_EDGE_RISE16:
            cap_evt[g] = rise[g + 2] & (div_reg[g] == tcpc_pkg::DIV16_LAST);
          default: cap_evt[g] = 1'b0;
        endcase
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) div_reg[g] <= 4'h0;
        else if (mode == tcpc_pkg::TCPC_EDGE_RISE4 && rise[g + 2])
          div_reg[g] <= (div_reg[g] == tcpc_pkg::DIV4_LAST) ? 4'h0 :
                        div_reg[g] + 4'h1;
        else if (rise[g + 2]) div_reg[g] <= div_reg[g] + 4'h1;
      end
      assign rd_lo = rd && hit(paddr, lo_idx[g]);
      assign rd_hi = rd && hit(paddr, hi_idx[g]);
      assign both_read = (cap_reg[g].lo_read | rd_lo) &
                         (cap_reg[g].hi_read | rd_hi);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          // Nothing held after reset, so the first capture is no overrun
          cap_reg[g] <= '{value: 16'h0000, lo_read: 1'b1, hi_read: 1'b1,
                          overrun: 1'b0};
        end else if (cap_ok[g] && cap_evt[g] &&
                     !(cap_reg[g].lo_read && cap_reg[g].hi_read) &&
                     !both_read) begin
          cap_reg[g].overrun <= 1'b1; // keep oldest value
        end else if (cap_ok[g] && cap_evt[g] && !cap_reg[g].overrun) begin
          cap_reg[g].value <= timer_c_reg;
          cap_reg[g].lo_read <= 1'b0;
          cap_reg[g].hi_read <= 1'b0;
        end else if (both_read) begin
          cap_reg[g].lo_read <= 1'b1;
          cap_reg[g].hi_read <= 1'b1;
          cap_reg[g].overrun <= 1'b0;
        end else begin
          cap_reg[g].lo_read <= cap_reg[g].lo_read | rd_lo;
          cap_reg[g].hi_read <= cap_reg[g].hi_read | rd_hi;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Control registers and flags
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_config_reg <= tcpc_pkg::CTRL_RESET;
      timer_run_control_reg <= tcpc_pkg::CTRL_RESET;
      portb_direction_reg <= tcpc_pkg::DIR_RESET;
      period_a_reg <= 8'h00;
      period_b_reg <= 8'h00;
    end else begin
      if (wr && hit(paddr, tcpc_pkg::IDX_CONFIG))
        timer_config_reg <= pwdata[7:0];
      if (wr && hit(paddr, tcpc_pkg::IDX_DIR))
        portb_direction_reg <= pwdata[7:0];
      if (wr && hit(paddr, tcpc_pkg::IDX_PA)) period_a_reg <= pwdata[7:0];
      if (wr && hit(paddr, tcpc_pkg::IDX_PB)) period_b_reg <= pwdata[7:0];
      // Overrun bits are read-only mirrors of the capture state
      if (wr && hit(paddr, tcpc_pkg::IDX_RUN))
        timer_run_control_reg <= {tcpc_pkg::RUN_WMASK_HI, pwdata[5:0]};
    end
  end

  // Sticky flags; a new event wins over a software clear
  logic [4:0] flag_set;
  assign flag_set = {cap_ok[1] & cap_evt[1], cap_ok[0] & cap_evt[0],
                     run_c & tick_c & (capsel ? timer_c_reg == 16'hffff
                                              : roll_c),
                     roll_b & ~pair, roll_a};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flags_reg <= 5'h00;
    else if (wr && hit(paddr, tcpc_pkg::IDX_FLAGS))
      flags_reg <= (flags_reg & ~pwdata[4:0]) | flag_set;
    else flags_reg <= flags_reg | flag_set;
  end
  assign irq_flags = {1'b0, flags_reg};

  // ==========================================================
  // Read mux
  // ==========================================================
  logic [7:0] rbyte;
  always_comb begin
    rbyte = 8'h00;
    if (hit(paddr, tcpc_pkg::IDX_CONFIG)) rbyte = timer_config_reg;
    if (hit(paddr, tcpc_pkg::IDX_RUN))
      rbyte = {cap_reg[1].overrun, cap_reg[0].overrun,
               timer_run_control_reg[5:0]};
    if (hit(paddr, tcpc_pkg::IDX_TA)) rbyte = timer_a_reg;
    if (hit(paddr, tcpc_pkg::IDX_TB)) rbyte = timer_b_reg;
    if (hit(paddr, tcpc_pkg::IDX_PA)) rbyte = period_a_reg;
    if (hit(paddr, tcpc_pkg::IDX_PB)) rbyte = period_b_reg;
    if (hit(paddr, tcpc_pkg::IDX_TC_LO)) rbyte = timer_c_reg[7:0];
    if (hit(paddr, tcpc_pkg::IDX_TC_HI)) rbyte = timer_c_reg[15:8];
    if (hit(paddr, tcpc_pkg::IDX_SH_LO))
      rbyte = capsel ? cap_reg[0].value[7:0] : period_c_reg[7:0];
    if (hit(paddr, tcpc_pkg::IDX_SH_HI))
      rbyte = capsel ? cap_reg[0].value[15:8] : period_c_reg[15:8];
    if (hit(paddr, tcpc_pkg::IDX_CB_LO)) rbyte = cap_reg[1].value[7:0];
    if (hit(paddr, tcpc_pkg::IDX_CB_HI)) rbyte = cap_reg[1].value[15:8];
    if (hit(paddr, tcpc_pkg::IDX_FLAGS)) rbyte = {3'h0, flags_reg};
    if (hit(paddr, tcpc_pkg::IDX_DIR)) rbyte = portb_direction_reg;
  end
  assign prdata = {24'h000000, rbyte};

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_timer_a_roll: assert property (
    (!pair && step_a && match_a && !(wr && hit(paddr, tcpc_pkg::IDX_TA)))
      |=> timer_a_reg == 8'h00 && flags_reg[tcpc_pkg::FLG_TA])
    else $error("timer a did not roll over");
  a_timer_c_stop: assert property (
    (!run_c && !wr) |=> $stable(timer_c_reg))
    else $error("timer c moved while stopped");
  a_cap_value: assert property (
    (cap_evt[1] && !cap_reg[1].overrun && cap_reg[1].lo_read &&
     cap_reg[1].hi_read) |=> cap_reg[1].value == $past(timer_c_reg))
    else $error("capture b missed timer c");
  a_cap_overrun: assert property (
    cap_reg[1].overrun && !rd |=> $stable(cap_reg[1].value))
    else $error("capture updated during overrun");
  a_pwm_force: assert property (
    timer_run_control_reg[tcpc_pkg::RUN_PWMA] |-> pwm_a_oe)
    else $error("pwm a not driven");
  a_cap_flag: assert property (
    cap_evt[1] |=> flags_reg[tcpc_pkg::FLG_CB])
    else $error("capture b flag not set");
  a_int_rate: assert property (
    int_tick |=> !int_tick [*3] ##1 int_tick)
    else $error("internal tick not one in four");
  a_sync_delay: assert property (
    (run_c && timer_config_reg[tcpc_pkg::CFG_T3_CS] && fall[1] && !wr &&
     !roll_c) |=> timer_c_reg == $past(timer_c_reg) + 16'h0001)
    else $error("timer c missed a synchronised edge");

  c_cap_overrun: cover property (cap_reg[0].overrun);
  c_pair_roll: cover property (pair && roll_a);
  c_c_roll: cover property (roll_c);

endmodule : tcpc_top

// ==== test/timer_capture_pwm_control_bench.sv ====
/*
  Self-checking bench for tcpc_top: APB register access, timers A/B,
  pair mode, external clock, capture edge modes, overrun, PWM pins.
  Assumes the zero-wait APB slave and pclk/4 tick of the hand-over.
*/
module timer_capture_pwm_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic rd; logic [31:0] data; logic err;} tcpc_note_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, ext_clk_ab = 1'b1, ext_clk_c = 1'b1;
  logic cap_a_pin = 1'b0, cap_b_pin = 1'b0, pready, pslverr;
  logic pwm_a_oe, pwm_b_oe, pwm_period_a, pwm_period_b;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [5:0] irq_flags;
  tcpc_note_t notes[$];
  int num_errors = 0, checks_done = 0, seed = 82, n, p, q;
  // ==========================================================
  // Clock and device
  // ==========================================================
  always #20 pclk = ~pclk;
  tcpc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clk_ab(ext_clk_ab), .ext_clk_c(ext_clk_c),
    .cap_a_pin(cap_a_pin), .cap_b_pin(cap_b_pin), .irq_flags(irq_flags),
    .pwm_a_oe(pwm_a_oe), .pwm_b_oe(pwm_b_oe),
    .pwm_period_a(pwm_period_a), .pwm_period_b(pwm_period_b));
  // ==========================================================
  // Checking and closing
  // ==========================================================
  task automatic check(input logic [31:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  // Monitor takes the oldest note whenever an access completes
  always @(posedge pclk) begin
    tcpc_note_t nt;
    if (psel && penable && pready) begin
      nt = notes.pop_front();
      if (nt.rd) check(prdata, nt.data, "read data");
      check({31'h0, pslverr}, {31'h0, nt.err}, "slave error");
    end
  end
  // Watchdog: the whole run needs well under this span
  initial begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    stop_test();
  end
  // ==========================================================
  // Drivers
  // ==========================================================
  // Request is held until pready is sampled high with penable
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] d, input logic err = 1'b0);
    int w;
    notes.push_back('{~wr, d, err});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wr ? d : 32'h0;
    @(posedge pclk);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge pclk);
      w++;
    end while (!pready && w < 100);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset
  task automatic cap_edge(input logic a, b);
    cap_a_pin <= a;
    cap_b_pin <= b;
    repeat (10) @(posedge pclk);
  endtask : cap_edge
  task automatic wait_pulse(input logic sel, output int cnt);
    cnt = 0;
    do begin
      @(posedge pclk);
      cnt++;
    end while (!(sel ? pwm_period_b : pwm_period_a) && cnt < 3000);
  endtask : wait_pulse
  // ==========================================================
  // Scenarios
  // ==========================================================
  initial begin
    do_reset();
    // Reset values, read-only overrun bits, unmapped word
    apb(0, tcpc_pkg::IDX_CONFIG, 32'h0);
    apb(0, tcpc_pkg::IDX_RUN, 32'h0);
    apb(0, tcpc_pkg::IDX_DIR, 32'hff);
    apb(1, tcpc_pkg::IDX_CONFIG, 32'ha5);
    apb(0, tcpc_pkg::IDX_CONFIG, 32'ha5);
    apb(1, tcpc_pkg::IDX_RUN, 32'hf0);
    apb(0, tcpc_pkg::IDX_RUN, 32'h30);
    apb(1, 8'h3f, 32'h12, 1'b1);
    apb(0, 8'h3f, 32'h0, 1'b1);
    // PWM enable overrides direction, else direction decides
    @(negedge pclk);
    check({31'h0, pwm_a_oe}, 32'h1, "pwm a oe");
    check({31'h0, pwm_b_oe}, 32'h1, "pwm b oe");
    apb(1, tcpc_pkg::IDX_RUN, 32'h10);
    apb(1, tcpc_pkg::IDX_DIR, 32'hf7);
    @(negedge pclk);
    check({31'h0, pwm_a_oe}, 32'h1, "pwm a oe");
    check({31'h0, pwm_b_oe}, 32'h1, "pwm b oe");
    apb(1, tcpc_pkg::IDX_RUN, 32'h0);
    @(negedge pclk);
    check({31'h0, pwm_a_oe}, 32'h0, "pwm a oe");
    // Random periods: pulse spacing is (period+1) ticks of pclk/4
    repeat (3) begin
      do_reset();
      p = ($random(seed) & 32'h1f) + 1;
      q = ($random(seed) & 32'h1f) + 1;
      apb(1, tcpc_pkg::IDX_PA, p);
      apb(1, tcpc_pkg::IDX_PB, q);
      apb(1, tcpc_pkg::IDX_RUN, 32'h03);
      wait_pulse(0, n);
      wait_pulse(0, n);
      check(n, (p + 1) * 4, "timer a spacing");
      wait_pulse(1, n);
      wait_pulse(1, n);
      check(n, (q + 1) * 4, "timer b spacing");
      check({31'h0, irq_flags[1]}, 32'h1, "timer b flag");
    end
    // Pair mode, period 0x0100: 257 ticks; upper byte needs its run bit
    for (int r = 0; r < 2; r++) begin
      do_reset();
      apb(1, tcpc_pkg::IDX_PB, 32'h01);
      apb(1, tcpc_pkg::IDX_CONFIG, 32'h08);
      apb(1, tcpc_pkg::IDX_RUN, r ? 32'h03 : 32'h01);
      repeat (950) @(posedge pclk);
      check({31'h0, irq_flags[0]}, 32'h0, "pair flag early");
      repeat (150) @(posedge pclk);
      check({31'h0, irq_flags[0]}, r, "pair flag");
    end
    // External clock: period 2 rolls on the third falling edge
    do_reset();
    apb(1, tcpc_pkg::IDX_PA, 32'h02);
    apb(1, tcpc_pkg::IDX_CONFIG, 32'h01);
    apb(1, tcpc_pkg::IDX_RUN, 32'h01);
    for (int i = 0; i < 3; i++) begin
      check({31'h0, irq_flags[0]}, 32'h0, "ext count flag");
      ext_clk_ab <= 1'b0;
      repeat (8) @(posedge pclk);
      ext_clk_ab <= 1'b1;
      repeat (8) @(posedge pclk);
    end
    check({31'h0, irq_flags[0]}, 32'h1, "ext count flag");
    // Timer C on its own pin, capture selected so no period limit
    do_reset();
    apb(1, tcpc_pkg::IDX_CONFIG, 32'h04);
    apb(1, tcpc_pkg::IDX_RUN, 32'h0c);
    repeat (3) begin
      ext_clk_c <= 1'b0;
      repeat (8) @(posedge pclk);
      ext_clk_c <= 1'b1;
      repeat (8) @(posedge pclk);
    end
    apb(0, tcpc_pkg::IDX_TC_LO, 32'h03);
    // Capture edge modes on channel b: 1 fall, 1, 4, 16 rises
    for (int m = 0; m < 4; m++) begin
      do_reset();
      apb(1, tcpc_pkg::IDX_CONFIG, m << 6);
      apb(1, tcpc_pkg::IDX_RUN, 32'h08);
      n = (m < 2) ? 1 : (m == 2 ? 4 : 16);
      for (int i = 0; i < n; i++) begin
        if (i == n - 1) check({31'h0, irq_flags[4]}, 32'h0, "cap mode");
        cap_edge(0, 1);
        if (m == 0) check({31'h0, irq_flags[4]}, 32'h0, "cap fall");
        cap_edge(0, 0);
      end
      check({31'h0, irq_flags[4]}, 32'h1, "cap mode flag");
    end
    // Capture value, overrun keeps oldest, both reads resume
    do_reset();
    apb(1, tcpc_pkg::IDX_CONFIG, 32'h50);
    apb(1, tcpc_pkg::IDX_RUN, 32'h08);
    apb(1, tcpc_pkg::IDX_TC_LO, 32'h34); // timer c stopped
    apb(1, tcpc_pkg::IDX_TC_HI, 32'h12);
    cap_edge(1, 1);
    cap_edge(0, 0);
    check({31'h0, irq_flags[3]}, 32'h1, "cap a flag");
    apb(0, tcpc_pkg::IDX_SH_LO, 32'h34);
    apb(0, tcpc_pkg::IDX_SH_HI, 32'h12);
    apb(1, tcpc_pkg::IDX_TC_LO, 32'hab);
    apb(1, tcpc_pkg::IDX_TC_HI, 32'h00);
    cap_edge(0, 1);
    apb(0, tcpc_pkg::IDX_RUN, 32'h88);
    apb(0, tcpc_pkg::IDX_CB_LO, 32'h34);
    apb(0, tcpc_pkg::IDX_CB_HI, 32'h12);
    apb(0, tcpc_pkg::IDX_RUN, 32'h08);
    cap_edge(0, 0);
    cap_edge(0, 1);
    apb(0, tcpc_pkg::IDX_CB_LO, 32'hab);
    apb(0, tcpc_pkg::IDX_CB_HI, 32'h00);
    repeat (4) @(posedge pclk);
    check(notes.size(), 0, "notes left");
    stop_test();
  end
endmodule : timer_capture_pwm_control_bench
